// file: design/afdel_pkg.sv
// Package of the audio FIFO DMA event logic: register map, field layout,
// reset values and sizes. Assumes a 32-bit AHB-Lite register bus.
package afdel_pkg;

  localparam int          DATA_W       = 32;
  localparam int          FIFO_DEPTH   = 64;
  localparam int          PTR_W        = 6;
  localparam int          LVL_W        = 7;
  localparam int          THR_W        = 8;
  localparam int          BUF_DEPTH    = 2;

  // Byte addresses of the registers
  localparam logic [3:0]  ADDR_RX_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_TX_CTRL = 4'h4;
  localparam logic [3:0]  ADDR_STATUS  = 4'h8;

  // Fields of rx_fifo_control and tx_fifo_control
  localparam int          CTL_EN       = 0;
  localparam int          CTL_SEL      = 1;
  localparam int          CTL_FIX      = 2;
  localparam int          CTL_FLUSH    = 3;
  localparam int          CTL_THR_LO   = 8;
  localparam int          CTL_THR_HI   = 15;
  localparam logic [15:0] CTL_RST      = 16'h0000;
  localparam logic [15:0] CTL_KEEP     = 16'hFF07;

  // Fields of the status register
  localparam int          ST_RXLVL_LO  = 0;
  localparam int          ST_TXLVL_LO  = 8;
  localparam int          ST_RX_OVF    = 16;
  localparam int          ST_TX_UDF    = 17;
  localparam int          ST_RX_EVT    = 18;
  localparam int          ST_TX_EVT    = 19;

  // Channel indices
  localparam int          CH_RX        = 0;
  localparam int          CH_TX        = 1;

  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ   = 2'h3;

endpackage

// file: design/afdel_buf2.sv
// Two-entry valid/ready buffer between the receive FIFO and the DMA read port.
// Assumes the same clock, reset and clock enable as the top.
`timescale 1ns/10ps
module afdel_buf2
  import afdel_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              flush,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [DATA_W-1:0] in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [DATA_W-1:0]      out_data
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][DATA_W-1:0] ent;
    logic [1:0]                       cnt;
    logic                             rdy;
    logic                             vld;
  } afdel_buf_s;

  afdel_buf_s st_q;
  afdel_buf_s st_d;

  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop  = 1'b0;
    st_d = st_q;
    push = in_valid && st_q.rdy;
    pop  = (st_q.cnt != 2'h0) && out_ready;
    if (pop) begin
      st_d.ent[0] = st_q.ent[1];
    end
    if (push) begin
      if (st_q.cnt == 2'h0 || (st_q.cnt == 2'h1 && pop)) begin
        st_d.ent[0] = in_data;
      end else begin
        st_d.ent[1] = in_data;
      end
    end
    st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      st_d.cnt = 2'h0;
    end
    // Ready from the next level keeps the output a flop and never overruns
    st_d.rdy = (st_d.cnt < 2'h2);
    // Valid kept as its own flop so the DMA side sees a registered level
    st_d.vld = (st_d.cnt != 2'h0);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '{ent: '0, cnt: 2'h0, rdy: 1'b1, vld: 1'b0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign in_ready  = st_q.rdy;
  assign out_valid = st_q.vld;
  assign out_data  = st_q.ent[0];

endmodule

// file: design/afdel_top.sv
// Audio FIFO DMA event logic: two 64-word FIFOs, threshold events to DMA,
// AHB-Lite register slave. Assumes one clock and a single AHB-Lite slave.
//
// Function
// - Receive event threshold comes from rx_fifo_control bits 15 to 8.
// - Transmit event threshold comes from tx_fifo_control bits 15 to 8.
// - DMA moving one threshold of words clears one pending event.
// - Pins moving one threshold of words raise a new pending event.
// - Legacy mode: set within two cycles of a clear is lost.
// - A lost event leads to receive overflow or transmit underflow.
// - Each FIFO holds 64 words.
// - Events go to the enhanced or the system DMA controller.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module afdel_top
  import afdel_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Serial pin side
  input  wire logic              pin_rx_valid,
  input  wire logic [DATA_W-1:0] pin_rx_data,
  input  wire logic              pin_tx_take,
  output logic [DATA_W-1:0]      pin_tx_data,
  output logic                   pin_tx_valid,
  // DMA data side
  output logic                   dma_rx_valid,
  input  wire logic              dma_rx_ready,
  output logic [DATA_W-1:0]      dma_rx_data,
  input  wire logic              dma_tx_valid,
  output logic                   dma_tx_ready,
  input  wire logic [DATA_W-1:0] dma_tx_data,
  // Synchronization events
  output logic                   rx_evt_enhanced_dma,
  output logic                   rx_evt_system_dma,
  output logic                   tx_evt_enhanced_dma,
  output logic                   tx_evt_system_dma
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0][FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [1:0][PTR_W-1:0]                  wp;
    logic [1:0][PTR_W-1:0]                  rp;
    logic [1:0][LVL_W-1:0]                  lvl;
    logic [1:0][THR_W-1:0]                  pcnt;
    logic [1:0][THR_W-1:0]                  dcnt;
    logic [1:0][LVL_W-1:0]                  pend;
    logic [1:0]                             clr_hist;
    logic [1:0][15:0]                       ctrl;
    logic [1:0]                             err;
    logic [1:0]                             evt_e;
    logic [1:0]                             evt_s;
    logic                                   tx_rdy;
    logic [DATA_W-1:0]                      tx_data;
    logic                                   tx_valid;
    logic                                   wr_pend;
    logic                                   rd_pend;
    logic [3:0]                             addr;
    logic                                   hrdy;
    logic [31:0]                            rdata;
  } afdel_st_s;

  function automatic afdel_st_s rst_val();
    rst_val           = '0;
    rst_val.ctrl[0]   = CTL_RST;
    rst_val.ctrl[1]   = CTL_RST;
    rst_val.pend[1]   = 7'h01;
    rst_val.hrdy      = 1'b1;
  endfunction

  localparam afdel_st_s ST_RST = rst_val();

  // Threshold field of a control word
  function automatic logic [THR_W-1:0] thr_of(input logic [15:0] c);
    thr_of = c[CTL_THR_HI:CTL_THR_LO];
  endfunction

  // Counter step toward a threshold; zero threshold never fires
  function automatic logic hit(input logic [THR_W-1:0] cnt, input logic [THR_W-1:0] thr);
    hit = (thr != 8'h00) && ((cnt + 8'h01) == thr);
  endfunction

  afdel_st_s         st_q;
  afdel_st_s         st_d;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  logic              rx_pop;
  logic [1:0]        flush;
  logic [1:0]        push;
  logic [1:0]        pop;
  logic [1:0]        set_ev;
  logic [1:0]        clr_ev;
  logic [1:0]        en;
  logic              addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Receive data path into the two-entry buffer

  afdel_buf2 u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .flush     (flush[CH_RX]),
    .in_valid  (rx_pop),
    .in_ready  (buf_in_ready),
    .in_data   (st_q.mem[CH_RX][st_q.rp[CH_RX]]),
    .out_valid (buf_out_valid),
    .out_ready (dma_rx_ready),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d    = st_q;
    addr_ok = hsel && hready && (htrans == HTRANS_NSEQ || htrans == HTRANS_SEQ);
    en[0]   = st_q.ctrl[0][CTL_EN];
    en[1]   = st_q.ctrl[1][CTL_EN];
    // Flush only on a write data phase to the matching control word
    flush[CH_RX] = st_q.wr_pend && st_q.addr == ADDR_RX_CTRL && hwdata[CTL_FLUSH];
    flush[CH_TX] = st_q.wr_pend && st_q.addr == ADDR_TX_CTRL && hwdata[CTL_FLUSH];

    // FIFO traffic: rx fills from pins, tx fills from DMA
    push[CH_RX] = en[CH_RX] && pin_rx_valid && (st_q.lvl[CH_RX] != 7'h40);
    rx_pop      = en[CH_RX] && (st_q.lvl[CH_RX] != 7'h00) && buf_in_ready;
    pop[CH_RX]  = rx_pop;
    push[CH_TX] = en[CH_TX] && dma_tx_valid && st_q.tx_rdy;
    pop[CH_TX]  = en[CH_TX] && pin_tx_take && (st_q.lvl[CH_TX] != 7'h00);

    // Event causes, counted on the pin side and the DMA side
    set_ev[CH_RX] = en[CH_RX] && pin_rx_valid
                  && hit(st_q.pcnt[CH_RX], thr_of(st_q.ctrl[CH_RX]));
    clr_ev[CH_RX] = en[CH_RX] && buf_out_valid && dma_rx_ready
                  && hit(st_q.dcnt[CH_RX], thr_of(st_q.ctrl[CH_RX]));
    set_ev[CH_TX] = en[CH_TX] && pin_tx_take
                  && hit(st_q.pcnt[CH_TX], thr_of(st_q.ctrl[CH_TX]));
    clr_ev[CH_TX] = push[CH_TX]
                  && hit(st_q.dcnt[CH_TX], thr_of(st_q.ctrl[CH_TX]));

    for (int c = 0; c < 2; c++) begin
      if (push[c]) begin
        st_d.mem[c][st_q.wp[c]] = (c == CH_RX) ? pin_rx_data : dma_tx_data;
        st_d.wp[c]              = st_q.wp[c] + 6'h01;
      end
      if (pop[c]) begin
        st_d.rp[c] = st_q.rp[c] + 6'h01;
      end
      st_d.lvl[c] = st_q.lvl[c] + {6'h00, push[c]} - {6'h00, pop[c]};

      // Threshold counters
      if (set_ev[c]) begin
        st_d.pcnt[c] = 8'h00;
      end else if ((c == CH_RX) ? (en[c] && pin_rx_valid) : (en[c] && pin_tx_take)) begin
        st_d.pcnt[c] = st_q.pcnt[c] + 8'h01;
      end
      if (clr_ev[c]) begin
        st_d.dcnt[c] = 8'h00;
      end else if ((c == CH_RX) ? (en[c] && buf_out_valid && dma_rx_ready) : push[c]) begin
        st_d.dcnt[c] = st_q.dcnt[c] + 8'h01;
      end

      // Pending events
      st_d.clr_hist[c] = clr_ev[c];
      if (st_q.ctrl[c][CTL_FIX]) begin
        // Both edges counted, so nothing is dropped
        st_d.pend[c] = st_q.pend[c] + {6'h00, set_ev[c]}
                     - {6'h00, clr_ev[c] && (st_q.pend[c] != 7'h00)};
      end else begin
        // Old behaviour: a set meeting a clear in the two-cycle window vanishes
        if (clr_ev[c] && st_q.pend[c] != 7'h00) begin
          st_d.pend[c] = st_q.pend[c] - 7'h01;
        end
        if (set_ev[c] && !(clr_ev[c] || st_q.clr_hist[c])) begin
          st_d.pend[c] = st_d.pend[c] + 7'h01;
        end
      end

      // Sticky errors; set wins over the write-one clear
      if (st_q.wr_pend && st_q.addr == ADDR_STATUS && hwdata[ST_RX_OVF + c]) begin
        st_d.err[c] = 1'b0;
      end
      if ((c == CH_RX) ? (en[c] && pin_rx_valid && !push[c])
                       : (en[c] && pin_tx_take && !pop[c])) begin
        st_d.err[c] = 1'b1;
      end

      // Recovery: software flush empties the path and re-arms
      if (flush[c]) begin
        st_d.wp[c]       = 6'h00;
        st_d.rp[c]       = 6'h00;
        st_d.lvl[c]      = 7'h00;
        st_d.pcnt[c]     = 8'h00;
        st_d.dcnt[c]     = 8'h00;
        st_d.clr_hist[c] = 1'b0;
        st_d.pend[c]     = (c == CH_TX) ? 7'h01 : 7'h00;
      end
    end

    // Register writes in the data phase
    if (st_q.wr_pend) begin
      if (st_q.addr == ADDR_RX_CTRL) begin
        st_d.ctrl[CH_RX] = hwdata[15:0] & CTL_KEEP;
      end
      if (st_q.addr == ADDR_TX_CTRL) begin
        st_d.ctrl[CH_TX] = hwdata[15:0] & CTL_KEEP;
      end
    end

    // Event routing by the select bit
    for (int c = 0; c < 2; c++) begin
      st_d.evt_e[c] = st_d.ctrl[c][CTL_EN] && !st_d.ctrl[c][CTL_SEL]
                    && (st_d.pend[c] != 7'h00);
      st_d.evt_s[c] = st_d.ctrl[c][CTL_EN] && st_d.ctrl[c][CTL_SEL]
                    && (st_d.pend[c] != 7'h00);
    end

    // Transmit outputs toward pins and DMA
    if (pop[CH_TX]) begin
      st_d.tx_data = st_q.mem[CH_TX][st_q.rp[CH_TX]];
    end
    st_d.tx_valid = pop[CH_TX];
    st_d.tx_rdy   = st_d.ctrl[CH_TX][CTL_EN] && (st_d.lvl[CH_TX] != 7'h40);

    // Bus slave: writes zero wait, reads one wait so a prior write is seen
    st_d.wr_pend = 1'b0;
    st_d.hrdy    = 1'b1;
    if (st_q.rd_pend) begin
      st_d.rd_pend = 1'b0;
      case (st_q.addr)
        ADDR_RX_CTRL: st_d.rdata = {16'h0000, st_q.ctrl[CH_RX]};
        ADDR_TX_CTRL: st_d.rdata = {16'h0000, st_q.ctrl[CH_TX]};
        ADDR_STATUS: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rdata[ST_RXLVL_LO +: LVL_W] = st_q.lvl[CH_RX];
          st_d.rdata[ST_TXLVL_LO +: LVL_W] = st_q.lvl[CH_TX];
          st_d.rdata[ST_RX_OVF]            = st_q.err[CH_RX];
          st_d.rdata[ST_TX_UDF]            = st_q.err[CH_TX];
          st_d.rdata[ST_RX_EVT]            = st_q.pend[CH_RX] != 7'h00;
          st_d.rdata[ST_TX_EVT]            = st_q.pend[CH_TX] != 7'h00;
        end
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end else if (addr_ok) begin
      // Upper address bits ignored; unmapped words read zero, writes drop
      st_d.addr    = haddr[3:0];
      st_d.wr_pend = hwrite;
      st_d.rd_pend = !hwrite;
      st_d.hrdy    = hwrite;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= ST_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout           = st_q.hrdy;
  assign hrdata              = st_q.rdata;
  assign hresp               = 1'b0;
  assign pin_tx_data         = st_q.tx_data;
  assign pin_tx_valid        = st_q.tx_valid;
  assign dma_rx_valid        = buf_out_valid;
  assign dma_rx_data         = buf_out_data;
  assign dma_tx_ready        = st_q.tx_rdy;
  assign rx_evt_enhanced_dma = st_q.evt_e[CH_RX];
  assign rx_evt_system_dma   = st_q.evt_s[CH_RX];
  assign tx_evt_enhanced_dma = st_q.evt_e[CH_TX];
  assign tx_evt_system_dma   = st_q.evt_s[CH_TX];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_RX_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && set_ev[CH_RX] && !clr_ev[CH_RX] && !st_q.clr_hist[CH_RX] && !flush[CH_RX]
    |=> st_q.pend[CH_RX] == $past(st_q.pend[CH_RX]) + 7'h01)
    else $error("rx set did not raise pending");

  AST_TX_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && clr_ev[CH_TX] && !set_ev[CH_TX] && st_q.pend[CH_TX] != 7'h00 && !flush[CH_TX]
    |=> st_q.pend[CH_TX] == $past(st_q.pend[CH_TX]) - 7'h01)
    else $error("tx clear did not lower pending");

  AST_LOST: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !st_q.ctrl[CH_RX][CTL_FIX] && set_ev[CH_RX] && st_q.clr_hist[CH_RX]
    && !clr_ev[CH_RX] && !flush[CH_RX]
    |=> st_q.pend[CH_RX] == $past(st_q.pend[CH_RX]))
    else $error("legacy set in window was not dropped");

  AST_FIX: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_q.ctrl[CH_RX][CTL_FIX] && set_ev[CH_RX] && clr_ev[CH_RX]
    && st_q.pend[CH_RX] != 7'h00 && !flush[CH_RX]
    |=> st_q.pend[CH_RX] == $past(st_q.pend[CH_RX]))
    else $error("fixed mode lost a coincident set");

  AST_OVF: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && en[CH_RX] && pin_rx_valid && st_q.lvl[CH_RX] == 7'h40
    |=> st_q.err[CH_RX] ##1 (st_q.err[CH_RX] || $past(st_q.wr_pend)))
    else $error("rx overflow not flagged");

  AST_UDF: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && en[CH_TX] && pin_tx_take && st_q.lvl[CH_TX] == 7'h00
    |=> st_q.err[CH_TX] && !pin_tx_valid)
    else $error("tx underflow not flagged");

  AST_DEPTH: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q.lvl[CH_RX] <= 7'h40 && st_q.lvl[CH_TX] <= 7'h40
    && !(st_q.lvl[CH_TX] == 7'h40 && dma_tx_ready))
    else $error("FIFO level beyond depth");

  AST_ROUTE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rx_evt_enhanced_dma || rx_evt_system_dma)
    |-> st_q.pend[CH_RX] != 7'h00
        && rx_evt_system_dma == st_q.ctrl[CH_RX][CTL_SEL])
    else $error("rx event misrouted");

  AST_RX_THR: assert property (@(posedge core_clk) disable iff (!rst_n)
    set_ev[CH_RX] |-> st_q.pcnt[CH_RX] == st_q.ctrl[CH_RX][15:8] - 8'h01)
    else $error("rx event not at threshold");

  AST_TX_THR: assert property (@(posedge core_clk) disable iff (!rst_n)
    clr_ev[CH_TX] |-> st_q.dcnt[CH_TX] == st_q.ctrl[CH_TX][15:8] - 8'h01)
    else $error("tx clear not at threshold");

  AST_RD_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && addr_ok && !hwrite && !st_q.rd_pend |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule

// file: verif/afdel_dma_model.sv
// DMA engine model at the far side of the FIFO event logic.
// Assumes level events and valid/ready data ports on the same clock.
`timescale 1ns/10ps
module afdel_dma_model
  import afdel_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              hold,
  input  wire logic [THR_W-1:0]  thr,
  input  wire logic              rx_evt,
  input  wire logic              tx_evt,
  input  wire logic              dma_rx_valid,
  output logic                   dma_rx_ready,
  input  wire logic              dma_tx_ready,
  output logic                   dma_tx_valid,
  output logic [DATA_W-1:0]      dma_tx_data
);
  logic [THR_W-1:0]  rx_left_q;
  logic [THR_W-1:0]  tx_left_q;
  logic [2:0]        rx_gap_q;
  logic [2:0]        tx_gap_q;
  logic [DATA_W-1:0] tx_word_q;
  logic              rx_go;
  logic              tx_go;
  assign rx_go = dma_rx_valid && dma_rx_ready;
  assign tx_go = dma_tx_valid && dma_tx_ready;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_left_q    <= '0;
      tx_left_q    <= '0;
      rx_gap_q     <= 3'h0;
      tx_gap_q     <= 3'h0;
      dma_rx_ready <= 1'b0;
      dma_tx_valid <= 1'b0;
      dma_tx_data  <= 32'h0;
      tx_word_q    <= 32'hA000_0000;
    end else begin
      // One threshold burst per event; the gap lets the level settle
      if (rx_left_q != '0) begin
        if (rx_go) rx_left_q <= rx_left_q - 8'h01;
        if (rx_go && rx_left_q == 8'h01) rx_gap_q <= 3'h4;
        dma_rx_ready <= !hold && !(rx_go && rx_left_q == 8'h01);
      end else if (rx_gap_q != 3'h0) begin
        rx_gap_q <= rx_gap_q - 3'h1;
      end else if (rx_evt && !hold && thr != '0) begin
        rx_left_q    <= thr;
        dma_rx_ready <= 1'b1;
      end
      // Idle data toggles so a stale word never looks valid
      if (!dma_tx_valid) dma_tx_data <= ~dma_tx_data;
      if (tx_left_q != '0) begin
        if (tx_go) begin
          tx_left_q <= tx_left_q - 8'h01;
          tx_word_q <= tx_word_q + 32'h1;
          if (tx_left_q == 8'h01) tx_gap_q <= 3'h4;
        end
        if (!dma_tx_valid || dma_tx_ready) begin
          dma_tx_valid <= !hold && !(dma_tx_valid && tx_left_q == 8'h01);
          dma_tx_data  <= dma_tx_valid ? tx_word_q + 32'h1 : tx_word_q;
        end
      end else if (tx_gap_q != 3'h0) begin
        tx_gap_q <= tx_gap_q - 3'h1;
      end else if (tx_evt && !hold && thr != '0) begin
        tx_left_q    <= thr;
        dma_tx_valid <= 1'b1;
        dma_tx_data  <= tx_word_q;
      end
    end
  end
endmodule

// file: verif/test_audio_fifo_dma_event_logic.sv
// Self-checking bench of the FIFO event logic with a DMA model.
// Assumes one 200 MHz clock and a single AHB-Lite slave.
`timescale 1ns/10ps
module test_audio_fifo_dma_event_logic
  import afdel_pkg::*;
;
  logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hold = 0;
  logic [31:0] haddr = 0, hwdata = 0, pin_rx_data = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic pin_rx_valid = 0, pin_tx_take = 0, man_on = 0, man_ready = 0;
  logic [7:0] mdl_thr = 8'h04;
  logic hreadyout, hresp, pin_tx_valid, dma_rx_valid, dma_rx_ready, mdl_ready;
  logic dma_tx_valid, dma_tx_ready, rx_enh, rx_sys, tx_enh, tx_sys;
  logic rx_sys_seen = 0, tx_enh_seen = 0;
  logic [31:0] hrdata, pin_tx_data, dma_rx_data, dma_tx_data, rx_word = 32'hD000_0000;
  logic [31:0] rxq[$], txq[$];
  int mismatches = 0, n_compared = 0, cyc = 0;
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e;} afdel_row_s;
  afdel_row_s rows[5] = '{'{32'h0, 32'hFFFF_FFFF, 32'h0000_FF07},
                          '{32'h4, 32'h1234_5A0E, 32'h0000_5A06},
                          '{32'hC, 32'hFFFF_FFFF, 32'h0},
                          '{32'h0, 32'h0, 32'h0}, '{32'h4, 32'h0, 32'h0}};
  always #2.5 core_clk = ~core_clk;
  assign dma_rx_ready = man_on ? man_ready : mdl_ready;
  afdel_top DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pin_rx_valid(pin_rx_valid), .pin_rx_data(pin_rx_data), .pin_tx_take(pin_tx_take),
    .pin_tx_data(pin_tx_data), .pin_tx_valid(pin_tx_valid), .dma_rx_valid(dma_rx_valid),
    .dma_rx_ready(dma_rx_ready), .dma_rx_data(dma_rx_data), .dma_tx_valid(dma_tx_valid),
    .dma_tx_ready(dma_tx_ready), .dma_tx_data(dma_tx_data), .rx_evt_enhanced_dma(rx_enh),
    .rx_evt_system_dma(rx_sys), .tx_evt_enhanced_dma(tx_enh), .tx_evt_system_dma(tx_sys));
  afdel_dma_model MDL (.core_clk(core_clk), .rst_n(rst_n), .hold(hold), .thr(mdl_thr),
    .rx_evt(rx_enh | rx_sys), .tx_evt(tx_enh | tx_sys), .dma_rx_valid(dma_rx_valid),
    .dma_rx_ready(mdl_ready), .dma_tx_ready(dma_tx_ready), .dma_tx_valid(dma_tx_valid),
    .dma_tx_data(dma_tx_data));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (dma_rx_valid && dma_rx_ready) rxq.push_back(dma_rx_data);
    if (pin_tx_valid) txq.push_back(pin_tx_data);
    if (rx_sys) rx_sys_seen = 1;
    if (tx_enh) tx_enh_seen = 1;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Ready is looked at on the falling edge, half a cycle before the rising edge, where it is settled
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic r;
    hsel <= 1;
    haddr <= a;
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    do begin
      @(negedge core_clk) r = hreadyout;
      @(posedge core_clk);
    end while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge core_clk) r = hreadyout;
      rd = hrdata;
      @(posedge core_clk);
    end while (r !== 1'b1);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1, a, d, x);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] e);
    logic [31:0] x;
    ahb(0, a, 32'h0, x);
    chk(x & mask, e, "register read");
  endtask
  task automatic push(input int n);
    repeat (n) begin
      pin_rx_valid <= 1;
      pin_rx_data <= rx_word;
      rx_word = rx_word + 32'h1;
      @(posedge core_clk) pin_rx_valid <= 0;
      @(posedge core_clk);
    end
  endtask
  task automatic take(input int n, input int gap);
    repeat (n) begin
      pin_tx_take <= 1;
      @(posedge core_clk) pin_tx_take <= 0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    chk({rx_enh, rx_sys, tx_enh, tx_sys, hresp}, 0, "events after reset");
    rdc(32'h0, 32'hFFFF_FFFF, 32'h0);
    rdc(32'h4, 32'hFFFF_FFFF, 32'h0);
    rdc(32'h8, 32'hFFFF_FFFF, 32'h0008_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
    end
    // Threshold four: a serializer multiple under 32 words
    wr(32'h0, 32'h0000_0405);
    for (int k = 0; k < 4; k++) begin
      push(3);
      hold <= (k == 1);
      repeat (10) @(posedge core_clk);
    end
    hold <= 0;
    repeat (40) @(posedge core_clk);
    chk(rxq.size(), 12, "rx words at DMA");
    foreach (rxq[i]) chk(rxq[i], 32'hD000_0000 + i, "rx word order");
    chk(rx_sys_seen, 0, "rx routed to system DMA");
    wr(32'h4, 32'h0000_0407);
    repeat (30) @(posedge core_clk);
    take(12, 8);
    chk(txq.size(), 12, "tx words at pins");
    foreach (txq[i]) chk(txq[i], 32'hA000_0000 + i, "tx word order");
    chk(tx_enh_seen, 0, "tx routed to enhanced DMA");
    rdc(32'h8, 32'h000F_0000, 32'h0);
    hold <= 1;
    wr(32'h4, 32'h0000_0409);
    txq.delete();
    take(1, 3);
    chk(txq.size(), 0, "pulse on empty tx");
    rdc(32'h8, 32'h1 << ST_TX_UDF, 32'h1 << ST_TX_UDF);
    wr(32'h8, 32'h1 << ST_TX_UDF);
    rdc(32'h8, 32'h1 << ST_TX_UDF, 32'h0);
    wr(32'h4, 32'h0);
    man_on <= 1;
    // Legacy coincident, fix mode coincident, then legacy set one cycle late
    for (int f = 0; f < 3; f++) begin
      wr(32'h0, 32'h0000_0209 | ((f == 1) << CTL_FIX));
      push(3);
      repeat (6) @(posedge core_clk);
      chk(rx_enh, 1, "rx event at threshold");
      man_ready <= 1;
      @(posedge core_clk) pin_rx_valid <= (f < 2);
      @(posedge core_clk) pin_rx_valid <= (f == 2);
      man_ready <= 0;
      @(posedge core_clk) pin_rx_valid <= 0;
      repeat (2) @(posedge core_clk);
      chk(rx_enh, f == 1, "event after set and clear coincide");
    end
    wr(32'h0, 32'h0000_0009);
    push(66);
    rdc(32'h8, 32'h0001_007F, 32'h0000_0040);
    push(1);
    rdc(32'h8, 32'h0001_007F, 32'h0001_0040);
    wr(32'h8, 32'h1 << ST_RX_OVF);
    wr(32'h0, 32'h0000_0008);
    rdc(32'h8, 32'h0001_007F, 32'h0);
    end_sim();
  end
endmodule
